// ---- dv/dsp_core_command_interpreter_tb.sv ----
/*
  bench: host end and core end joined by the link, checked against a model.
  assumes the design files and package are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module dsp_core_command_interpreter_tb;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic word_req_i = 1'b0;
  logic first_word_i = 1'b0;
  logic [15:0] word_i = 16'h0000;
  logic read_req_i = 1'b0;
  logic frame_done_i = 1'b0;
  logic [3:0] prog_area_i = 4'h0;
  logic busy_o, read_done_o, irq_o, running_o, timeout_o;
  logic [15:0] read_word_o, pc_o, w;
  logic [15:0] seed = 16'h8439;
  logic [7:0] rq[$];
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int ba[4];
  int regs[256];
  int mem[2][2048];
  dspci_link_if dspci_link_if_i ();
  dspci_host dspci_host_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .link(dspci_link_if_i),
    .word_req_i(word_req_i), .first_word_i(first_word_i), .word_i(word_i),
    .read_req_i(read_req_i), .busy_o(busy_o), .read_word_o(read_word_o),
    .read_done_o(read_done_o), .irq_o(irq_o));
  // short timeout keeps the stalled-telegram case quick
  dspci_core #(.RESP_CYC(200)) dspci_core_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .link(dspci_link_if_i), .frame_done_i(frame_done_i), .prog_area_i(prog_area_i),
    .running_o(running_o), .pc_o(pc_o), .timeout_o(timeout_o));
  dspci_chk dspci_chk_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .wr_stb(dspci_link_if_i.wr_stb), .wr_data(dspci_link_if_i.wr_data),
    .new_cmd(dspci_link_if_i.new_cmd), .rd_stb(dspci_link_if_i.rd_stb),
    .rd_data(dspci_link_if_i.rd_data), .rd_valid(dspci_link_if_i.rd_valid),
    .sync_pin(dspci_link_if_i.sync_pin));
  always #50 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      wrap_up();
    end
  end
  ////////////////////////////////////////
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int rnd();
    seed = nx(seed);
    rnd = int'(seed[3:0]) << 16;
    seed = nx(seed);
    rnd = rnd | int'(seed);
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic wait_free();
    for (int k = 0; k < 50 && busy_o !== 1'b0; k++) idle(1);
  endtask
  task automatic send(input logic [15:0] d, input logic f);
    wait_free();
    word_req_i = 1'b1;
    first_word_i = f;
    word_i = d;
    idle(1);
    word_req_i = 1'b0;
    first_word_i = 1'b0;
  endtask
  // gap before each read covers ram latency and write-to-read spacing
  task automatic get();
    idle(3);
    wait_free();
    read_req_i = 1'b1;
    idle(1);
    read_req_i = 1'b0;
    for (int k = 0; k < 20 && read_done_o !== 1'b1; k++) idle(1);
    w = read_word_o;
  endtask
  task automatic rd_reg(input logic [7:0] r);
    send({4'hA, r, 4'h0}, 1'b1);
    get();
    check("reg high", regs[r][19:16], {12'h000, w[3:0]});
    get();
    check("reg low", regs[r][15:0], w);
  endtask
  task automatic mem_cmd(input logic [3:0] c, input bit sh, input logic [15:0] ad, input int n);
    send({c, sh ? 4'h4 : 4'h0, 8'h00}, 1'b1);
    send(n[15:0], 1'b0);
    send(ad, 1'b0);
  endtask
  task automatic mem_wr(input bit a, input bit sh, input logic [15:0] ad, input int n);
    int v;
    mem_cmd(a ? 4'hF : 4'hE, sh, ad, n);
    for (int i = 0; i < n; i++) begin
      v = rnd();
      if (!sh) send({12'h000, v[19:16]}, 1'b0);
      send(v[15:0], 1'b0);
      mem[a][ad[10:0] + i] = sh ? (v & 32'h0000FFFF) : v;
    end
  endtask
  task automatic mem_rd(input bit a, input bit sh, input logic [15:0] ad, input int n);
    int v;
    mem_cmd(a ? 4'hD : 4'hC, sh, ad, n);
    for (int i = 0; i < n; i++) begin
      v = mem[a][ad[10:0] + i];
      if (!sh) begin
        get();
        check("cell high", v[19:16], {12'h000, w[3:0]});
      end
      get();
      check("cell low", v[15:0], w);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    int v;
    idle(10);
    reset_i = 1'b0;
    prog_area_i = seed[3:0] | 4'h2;
    check("running", 16'h0001, {15'h0000, running_o});
    check("entry", 16'h0000, pc_o);
    for (int i = 0; i < 3; i++) begin
      v = rnd();
      rq.push_back(i == 0 ? 8'hFF : (i == 1 ? 8'h00 : v[7:0]));
      v = rnd();
      send({4'hB, rq[i], v[19:16]}, 1'b1);
      send(v[15:0], 1'b0);
      regs[rq[i]] = v;
    end
    foreach (rq[i]) rd_reg(rq[i]);
    $display("test registers done");
    send(16'h0000, 1'b1);
    for (int k = 0; k < 4; k++) begin
      ba[k] = rnd() & 32'h000007F0;
      mem_wr(k[0], k[1], ba[k][15:0], 3);
      mem_rd(k[0], 1'b0, ba[k][15:0], 3);
      mem_rd(k[0], 1'b1, ba[k][15:0], 3);
    end
    $display("test memory done");
    for (int k = 0; k < 2; k++) begin
      mem_cmd(4'hE, 1'b1, 16'h0FFB, 1);
      send({k[0], 4'h0, 11'(ba[k] + 1)}, 1'b0);
      mem[0][11'h7FB] = int'({k[0], 4'h0, 11'(ba[k] + 1)});
      repeat (2) begin
        v = mem[0][11'h7FB];
        v = mem[v[15]][v[10:0]];
        get();
        check("default read", v[15:0], w);
      end
    end
    $display("test default read done");
    for (int k = 1; k < 4; k++) begin
      send(16'h0000, 1'b1);
      idle(4);
      check("frozen", 16'h0000, {15'h0000, running_o});
      send(16'(k << 12), 1'b1);
      idle(4);
      check("run state", {15'h0000, prog_area_i[k]}, {15'h0000, running_o});
      if (prog_area_i[k]) check("run address", 16'(k << 12), pc_o);
      else check("run ignored", 16'h0000, pc_o);
    end
    $display("test run done");
    frame_done_i = 1'b1;
    idle(1);
    frame_done_i = 1'b0;
    idle(6);
    check("irq set", 16'h0001, {15'h0000, irq_o});
    send(16'h5010, 1'b1);
    idle(6);
    check("irq kept", 16'h0001, {15'h0000, irq_o});
    send(16'h5000, 1'b1);
    idle(6);
    check("irq clear", 16'h0000, {15'h0000, irq_o});
    $display("test sync done");
    // telegram abandoned after its first word
    send(16'hC000, 1'b1);
    for (int k = 0; k < 300 && timeout_o !== 1'b1; k++) idle(1);
    check("timeout", 16'h0001, {15'h0000, timeout_o});
    rd_reg(rq[0]);
    $display("test timeout done");
    wrap_up();
  end
endmodule // dsp_core_command_interpreter_tb
`default_nettype wire

// ---- dv/dspci_chk.sv ----
/*
  checker of the word link between host end and core end.
  assumes the bench hands it the link signals and the shared clock.
*/
`timescale 1ns/100ps
`default_nettype none
module dspci_chk (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic wr_stb,
  input wire logic [15:0] wr_data,
  input wire logic new_cmd,
  input wire logic rd_stb,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic sync_pin
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////
  // cycles since the last clear word, saturating so it never wraps
  logic [3:0] clr_age_reg;
  logic [3:0] clr_age_next;
  always_comb begin
    clr_age_next = (clr_age_reg == 4'hF) ? clr_age_reg : clr_age_reg + 4'h1;
    if (wr_stb && new_cmd && wr_data == 16'h5000) clr_age_next = 4'h0;
    if (reset_i) clr_age_next = 4'hF;
  end
  always_ff @(posedge sys_clk_i) clr_age_reg <= clr_age_next;
  ////////////////////////////////////////
  chk_read_answer: assert property (rd_stb |=> rd_valid)
    else $error("no answer after read strobe");
  chk_valid_cause: assert property (rd_valid |-> $past(rd_stb))
    else $error("read answer without strobe");
  chk_data_stands: assert property (!rd_valid |-> $stable(rd_data))
    else $error("read word changed outside an answer");
  chk_sync_clear: assert property (wr_stb && new_cmd && wr_data == 16'h5000 |-> ##[1:3] !sync_pin)
    else $error("sync pin not cleared");
  chk_sync_fall_cause: assert property ($fell(sync_pin) |-> clr_age_reg <= 4'h3)
    else $error("sync pin fell without clear word");
  chk_code_with_word: assert property (new_cmd |-> wr_stb)
    else $error("command start without word");
  chk_write_read_gap: assert property (wr_stb |=> !rd_stb)
    else $error("read right after write word");
  chk_reset_quiet: assert property ($fell(reset_i) |-> !sync_pin && !rd_valid)
    else $error("link not quiet after reset");
  cov_read: cover property (rd_valid);
  cov_sync_rise: cover property ($rose(sync_pin));
  cov_sync_fall: cover property ($fell(sync_pin));
endmodule // dspci_chk
`default_nettype wire

// ---- hw/dspci_core.sv ----
/*
  core end: command interpreter of the dsp core. decodes word telegrams,
  runs/freezes, reads and writes 256 registers and two data areas, drives
  the frame-sync pin and serves default reads.
  assumes the host keeps its ordering duties; one clock, sync reset.
*/
// Notes on behaviour
// - run code top nibble only 0 to 3
// - run 1000..3FFF in program area executes there
// - address zero freezes core, state kept
// - reset starts default software entry
// - host freezes before loading software
// - 256 registers, code A reads one
// - one register per command, no blocks
// - code B writes 20-bit register value
// - two 2048-word areas, C/E and D/F
// - full read returns two words per cell
// - sub-code 4 read returns low 16 bits
// - full write stores n 20-bit cells
// - short write clears upper four bits
// - frame decoded raises sync pin
// - code 5 with zeros clears sync
// - default read returns cell via pointer ffb
// - pointer msb selects second area
// - host loads pointer before default read
// - code is first nibble, 16-bit words msb-first
// - answer within 4 ms
`timescale 1ns/100ps
`default_nettype none
module dspci_core #(
  parameter int unsigned RESP_CYC = dspci_pkg::RESP_MAX_CYC
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  dspci_link_if.core link,
  input wire logic frame_done_i,
  input wire logic [3:0] prog_area_i,
  output logic running_o,
  output logic [15:0] pc_o,
  output logic timeout_o
);
  typedef enum {IDLE, W2, W3, W4, WDAT, RSEND, RWAIT} dspci_state_t;
  dspci_state_t st_reg, st_next;
  logic [3:0] code_reg, code_next, sub_reg, sub_next;
  logic [15:0] cnt_reg, cnt_next, addr_reg, addr_next, pc_reg, pc_next;
  logic [7:0] rnum_reg, rnum_next;
  logic half_reg, half_next, run_reg, run_next, sync_reg, sync_next;
  logic [15:0] rd_reg, rd_next, hi_reg, hi_next;
  logic rv_reg, rv_next, to_reg, to_next;
  logic [19:0] regs [dspci_pkg::NUM_REGS];
  logic [19:0] reg_wdata;
  logic reg_we;
  logic [22:0] tcnt_reg, tcnt_next;
  logic we0, we1;
  logic [10:0] waddr, raddr0, raddr1;
  logic [19:0] wdata, q0, q1;
  logic [19:0] q_sel;
  logic [15:0] ptr_reg, ptr_next;
  ////////////////////////////////////////////////////////////////
  function automatic logic is_mem(input logic [3:0] c);
    return c >= dspci_pkg::CODE_RD_D0;
  endfunction
  dspci_mem #(.WORDS(dspci_pkg::MEM_WORDS), .AW(dspci_pkg::MEM_AW)) u_d0 (
    .sys_clk_i(sys_clk_i), .we_i(we0), .waddr_i(waddr), .wdata_i(wdata),
    .raddr_i(raddr0), .rdata_o(q0));
  dspci_mem #(.WORDS(dspci_pkg::MEM_WORDS), .AW(dspci_pkg::MEM_AW)) u_d1 (
    .sys_clk_i(sys_clk_i), .we_i(we1), .waddr_i(waddr), .wdata_i(wdata),
    .raddr_i(raddr1), .rdata_o(q1));
  assign q_sel = (code_reg == dspci_pkg::CODE_RD_D1) ? q1 : q0;
  ////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    code_next = code_reg;
    sub_next = sub_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    rnum_next = rnum_reg;
    half_next = half_reg;
    run_next = run_reg;
    pc_next = pc_reg;
    sync_next = sync_reg | frame_done_i;
    rd_next = rd_reg;
    hi_next = hi_reg;
    rv_next = 1'b0;
    ptr_next = ptr_reg;
    reg_we = 1'b0;
    reg_wdata = 20'h00000;
    we0 = 1'b0;
    we1 = 1'b0;
    waddr = addr_reg[10:0];
    wdata = 20'h00000;
    raddr0 = addr_reg[10:0];
    raddr1 = addr_reg[10:0];
    if (st_reg == IDLE) begin
      raddr0 = ptr_reg[10:0];
      raddr1 = ptr_reg[10:0];
    end
    if (link.wr_stb && link.new_cmd) begin
      code_next = link.wr_data[15:12];
      sub_next = link.wr_data[11:8];
      half_next = 1'b0;
      if (link.wr_data[15:12] <= dspci_pkg::CODE_RUN_HI) begin
        pc_next = link.wr_data;
        run_next = (link.wr_data != 16'h0000);
        if (link.wr_data >= dspci_pkg::PROG_LO && link.wr_data <= dspci_pkg::PROG_HI
            && !prog_area_i[link.wr_data[13:12]]) begin
          run_next = run_reg;
          pc_next = pc_reg;
        end
        st_next = IDLE;
      end else if (link.wr_data == 16'h5000) begin
        sync_next = frame_done_i;
        st_next = IDLE;
      end else if (link.wr_data[15:12] == dspci_pkg::CODE_RD_REG) begin
        rnum_next = link.wr_data[11:4];
        st_next = IDLE;
        hi_next = {12'h000, regs[link.wr_data[11:4]][19:16]};
        // low half parked in addr_reg so rd_data only moves on a read
        addr_next = regs[link.wr_data[11:4]][15:0];
        half_next = 1'b1;
      end else if (link.wr_data[15:12] == dspci_pkg::CODE_WR_REG) begin
        rnum_next = link.wr_data[11:4];
        hi_next = {12'h000, link.wr_data[3:0]};
        st_next = W2;
      end else if (is_mem(link.wr_data[15:12])) begin
        st_next = W3;
      end else begin
        st_next = IDLE;
      end
    end else if (link.wr_stb) begin
      case (st_reg)
        W2: begin
          reg_we = 1'b1;
          reg_wdata = {hi_reg[3:0], link.wr_data};
          st_next = IDLE;
        end
        W3: begin
          cnt_next = link.wr_data;
          st_next = W4;
        end
        W4: begin
          addr_next = link.wr_data;
          if (cnt_reg == 16'h0000) begin
            st_next = IDLE;
          end else if (code_reg >= dspci_pkg::CODE_WR_D0) begin
            st_next = WDAT;
          end else begin
            st_next = RSEND;
          end
        end
        WDAT: begin
          if (sub_reg == dspci_pkg::SUB_FULL && !half_reg) begin
            hi_next = link.wr_data;
            half_next = 1'b1;
          end else begin
            wdata = (sub_reg == dspci_pkg::SUB_SHORT) ? {4'h0, link.wr_data}
                                                      : {hi_reg[3:0], link.wr_data};
            we0 = (code_reg == dspci_pkg::CODE_WR_D0);
            we1 = (code_reg == dspci_pkg::CODE_WR_D1);
            if (we0 && addr_reg[10:0] == dspci_pkg::DEF_PTR_ADDR) begin
              ptr_next = link.wr_data;
            end
            half_next = 1'b0;
            addr_next = addr_reg + 16'h0001;
            cnt_next = cnt_reg - 16'h0001;
            if (cnt_reg == 16'h0001) begin
              st_next = IDLE;
            end
          end
        end
        default: st_next = st_reg;
      endcase
    end
    if (link.rd_stb) begin
      case (st_reg)
        RSEND, RWAIT: begin
          st_next = RWAIT;
          rv_next = 1'b1;
          if (sub_reg == dspci_pkg::SUB_FULL && !half_reg) begin
            rd_next = {12'h000, q_sel[19:16]};
            hi_next = q_sel[15:0];
            half_next = 1'b1;
          end else begin
            rd_next = (sub_reg == dspci_pkg::SUB_SHORT) ? q_sel[15:0] : hi_reg;
            half_next = 1'b0;
            addr_next = addr_reg + 16'h0001;
            cnt_next = cnt_reg - 16'h0001;
            if (cnt_reg == 16'h0001) begin
              st_next = IDLE;
            end
          end
        end
        default: begin
          if (code_reg == dspci_pkg::CODE_RD_REG && half_reg) begin
            rd_next = hi_reg;
            half_next = 1'b0;
          end else if (code_reg == dspci_pkg::CODE_RD_REG) begin
            rd_next = addr_reg;
            // later bare reads are default reads again
            code_next = 4'h0;
          end else begin
            rd_next = ptr_reg[15] ? q1[15:0] : q0[15:0];
          end
          rv_next = 1'b1;
        end
      endcase
    end
    // the 4 ms bound is watched, not enforced: decoding is single-cycle here
    to_next = 1'b0;
    tcnt_next = (st_reg == IDLE) ? 23'h000000 : tcnt_reg + 23'h000001;
    if (tcnt_reg >= 23'(RESP_CYC)) begin
      to_next = 1'b1;
      st_next = IDLE;
      tcnt_next = 23'h000000;
    end
  end
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i) begin
    if (reg_we) begin
      regs[rnum_reg] <= reg_wdata;
    end
    if (reset_i) begin
      st_reg <= IDLE;
      code_reg <= 4'h0;
      sub_reg <= 4'h0;
      cnt_reg <= 16'h0000;
      addr_reg <= 16'h0000;
      rnum_reg <= 8'h00;
      half_reg <= 1'b0;
      run_reg <= 1'b1;
      pc_reg <= dspci_pkg::ENTRY_DEFAULT;
      sync_reg <= 1'b0;
      rd_reg <= 16'h0000;
      hi_reg <= 16'h0000;
      rv_reg <= 1'b0;
      ptr_reg <= 16'h0000;
      to_reg <= 1'b0;
      tcnt_reg <= 23'h000000;
    end else begin
      st_reg <= st_next;
      code_reg <= code_next;
      sub_reg <= sub_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      rnum_reg <= rnum_next;
      half_reg <= half_next;
      run_reg <= run_next;
      pc_reg <= pc_next;
      sync_reg <= sync_next;
      rd_reg <= rd_next;
      hi_reg <= hi_next;
      rv_reg <= rv_next;
      ptr_reg <= ptr_next;
      to_reg <= to_next;
      tcnt_reg <= tcnt_next;
    end
  end
  assign link.rd_data = rd_reg;
  assign link.rd_valid = rv_reg;
  assign link.sync_pin = sync_reg;
  assign running_o = run_reg;
  assign pc_o = pc_reg;
  assign timeout_o = to_reg;
endmodule // dspci_core
`default_nettype wire

// ---- hw/dspci_host.sv ----
/*
  host end: turns user requests into word telegrams on the link and
  collects read words. one word per request; the user sequences telegrams.
  assumes the core answers reads one cycle after rd_stb.
*/
`timescale 1ns/100ps
`default_nettype none
module dspci_host (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  dspci_link_if.host link,
  input wire logic word_req_i,
  input wire logic first_word_i,
  input wire logic [15:0] word_i,
  input wire logic read_req_i,
  output logic busy_o,
  output logic [15:0] read_word_o,
  output logic read_done_o,
  output logic irq_o
);
  logic wr_stb_reg, wr_stb_next, new_reg, new_next, rd_reg, rd_next;
  logic busy_reg, busy_next, done_reg, done_next, irq_reg, irq_next;
  logic [15:0] wd_reg, wd_next, rw_reg, rw_next;
  logic [2:0] sync_sh_reg, sync_sh_next;
  ////////////////////////////////////////////////////////////////
  always_comb begin
    wr_stb_next = 1'b0;
    new_next = 1'b0;
    rd_next = 1'b0;
    done_next = 1'b0;
    wd_next = wd_reg;
    rw_next = rw_reg;
    busy_next = busy_reg;
    if (!busy_reg && word_req_i) begin
      wr_stb_next = 1'b1;
      new_next = first_word_i;
      wd_next = word_i;
    end else if (!busy_reg && read_req_i) begin
      rd_next = 1'b1;
      busy_next = 1'b1;
    end
    if (busy_reg && link.rd_valid) begin
      rw_next = link.rd_data;
      done_next = 1'b1;
      busy_next = 1'b0;
    end
    // level taken once two stages agree, one odd sample is ignored
    sync_sh_next = {sync_sh_reg[1:0], link.sync_pin};
    irq_next = irq_reg;
    if (sync_sh_reg[2] == sync_sh_reg[1]) begin
      irq_next = sync_sh_reg[1];
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wr_stb_reg <= 1'b0;
      new_reg <= 1'b0;
      rd_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      irq_reg <= 1'b0;
      wd_reg <= 16'h0000;
      rw_reg <= 16'h0000;
      sync_sh_reg <= 3'h0;
    end else begin
      wr_stb_reg <= wr_stb_next;
      new_reg <= new_next;
      rd_reg <= rd_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      irq_reg <= irq_next;
      wd_reg <= wd_next;
      rw_reg <= rw_next;
      sync_sh_reg <= sync_sh_next;
    end
  end
  assign link.wr_stb = wr_stb_reg;
  assign link.new_cmd = new_reg;
  assign link.wr_data = wd_reg;
  assign link.rd_stb = rd_reg;
  assign busy_o = busy_reg;
  assign read_word_o = rw_reg;
  assign read_done_o = done_reg;
  assign irq_o = irq_reg;
endmodule // dspci_host
`default_nettype wire

// ---- hw/dspci_link_if.sv ----
/*
  word link between host and dsp core: the data register seen as 16-bit
  words with a write strobe, a read strobe and the returned word.
  assumes both ends share sys_clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
interface dspci_link_if;
  logic wr_stb;
  logic [15:0] wr_data;
  logic new_cmd;
  logic rd_stb;
  logic [15:0] rd_data;
  logic rd_valid;
  logic sync_pin;
  modport core (input wr_stb, input wr_data, input new_cmd, input rd_stb,
                output rd_data, output rd_valid, output sync_pin);
  modport host (output wr_stb, output wr_data, output new_cmd, output rd_stb,
                input rd_data, input rd_valid, input sync_pin);
endinterface
`default_nettype wire

// ---- hw/dspci_mem.sv ----
/*
  one 2048 x 20 data area, one write port and one registered read port.
  assumes one clock, synchronous use only.
*/
`timescale 1ns/100ps
`default_nettype none
module dspci_mem #(
  parameter int unsigned WORDS = 2048,
  parameter int unsigned AW = 11
) (
  input wire logic sys_clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [19:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [19:0] rdata_o
);
  logic [19:0] mem [WORDS];
  always_ff @(posedge sys_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule // dspci_mem
`default_nettype wire

// ---- hw/dspci_pkg.sv ----
/*
  package of the dsp core command interpreter: command codes, sub-codes,
  memory sizes and timing counts. assumes a 10 MHz system clock.
*/
package dspci_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned RESP_MAX_US = 4000;
  localparam int unsigned RESP_MAX_CYC = RESP_MAX_US * (CLK_HZ / 1000000);
  localparam logic [3:0] CODE_RUN_HI = 4'h3;
  localparam logic [3:0] CODE_CLR_SYNC = 4'h5;
  localparam logic [3:0] CODE_RD_REG = 4'hA;
  localparam logic [3:0] CODE_WR_REG = 4'hB;
  localparam logic [3:0] CODE_RD_D0 = 4'hC;
  localparam logic [3:0] CODE_RD_D1 = 4'hD;
  localparam logic [3:0] CODE_WR_D0 = 4'hE;
  localparam logic [3:0] CODE_WR_D1 = 4'hF;
  localparam logic [3:0] SUB_FULL = 4'h0;
  localparam logic [3:0] SUB_SHORT = 4'h4;
  localparam int unsigned MEM_WORDS = 2048;
  localparam int unsigned MEM_AW = 11;
  localparam int unsigned NUM_REGS = 256;
  localparam logic [10:0] DEF_PTR_ADDR = 11'h7FB;
  localparam logic [15:0] PROG_LO = 16'h1000;
  localparam logic [15:0] PROG_HI = 16'h3FFF;
  localparam logic [15:0] ENTRY_DEFAULT = 16'h0000;
  localparam int unsigned PROG_AREAS = 4;
endpackage
